/* logic/adsc_pkg.sv */
// Shared constants and types for the sample controller and its driver
package adsc_pkg;
  // Device register map (byte offsets)
  localparam logic [7:0] ADSC_PIN_BASE   = 8'h04;
  localparam logic [7:0] ADSC_PIN_LAST   = 8'h1c;
  localparam logic [7:0] ADSC_GEN_OFS    = 8'h20;
  localparam int         ADSC_PINS       = 7;
  // General control fields
  localparam int         ADSC_DROP_BIT   = 24;
  localparam int         ADSC_WIDTH_LO   = 16;
  localparam int         ADSC_CAL_BIT    = 1;
  localparam int         ADSC_EN_BIT     = 0;
  localparam logic       ADSC_DROP_RST   = 1'b1;
  localparam logic [1:0] ADSC_WIDTH_RST  = 2'h1;
  localparam logic       ADSC_CAL_RST    = 1'b0;
  localparam logic       ADSC_EN_RST     = 1'b0;
  // Per-pin fields
  localparam int         ADSC_DEST_LO    = 8;
  localparam int         ADSC_PEN_BIT    = 0;
  localparam logic [23:0] ADSC_DEST_RST  = 24'h000000;
  localparam logic       ADSC_PEN_RST    = 1'b0;
  // Calibration pulses after enable
  localparam logic [2:0] ADSC_CAL_PULSES = 3'h6;
  // Full scale in microvolts of the internal reference
  localparam logic [19:0] ADSC_UV_NUM    = 20'hc3500;
  localparam logic [4:0] ADSC_DIV_STEPS  = 5'h14;

  typedef enum logic [1:0] {
    ADSC_W8   = 2'b00,
    ADSC_W16  = 2'b01,
    ADSC_WRSV = 2'b10,
    ADSC_W32  = 2'b11
  } adsc_width_type;

  // Driver register map (byte offsets)
  localparam logic [7:0] ADSC_C_CMD      = 8'h00;
  localparam logic [7:0] ADSC_C_WDATA    = 8'h04;
  localparam logic [7:0] ADSC_C_RDATA    = 8'h08;
  localparam logic [7:0] ADSC_C_STATUS   = 8'h0c;
  localparam logic [7:0] ADSC_C_MASK     = 8'h10;
  localparam logic [7:0] ADSC_C_SAMPLE   = 8'h14;
  localparam logic [7:0] ADSC_C_SCALE    = 8'h18;
  localparam logic [7:0] ADSC_C_UV       = 8'h1c;
  // Status bits
  localparam int         ADSC_S_DONE     = 0;
  localparam int         ADSC_S_SAMPLE   = 1;
  localparam int         ADSC_S_REFUSED  = 2;
  localparam int         ADSC_S_SCALE    = 3;

  typedef enum logic [1:0] {
    ADSC_OP_NONE  = 2'b00,
    ADSC_OP_READ  = 2'b01,
    ADSC_OP_WRITE = 2'b10,
    ADSC_OP_PULSE = 2'b11
  } adsc_op_type;

  typedef enum logic [1:0] {
    ADSC_CS_IDLE = 2'b00,
    ADSC_CS_WAIT = 2'b01,
    ADSC_CS_CAL  = 2'b10
  } adsc_cstate_type;
endpackage

/* logic/adsc_if.sv */
// Link between the sample controller and its driving tile
`timescale 1ns/1ps
`default_nettype none
interface adsc_if;
  // Register access
  logic        regReq;
  logic        regWrite;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regAck;
  logic [31:0] regRdata;
  // Sample pulses
  logic        pulse;
  logic [2:0]  pulsePin;
  // Sample packet bytes
  logic        pktValid;
  logic [7:0]  pktData;
  logic        pktLast;
  logic [23:0] pktDest;
  logic        pktReady;

  modport dev (input regReq, regWrite, regAddr, regWdata, pulse, pulsePin,
               pktReady,
               output regAck, regRdata, pktValid, pktData, pktLast, pktDest);
  modport ctl (output regReq, regWrite, regAddr, regWdata, pulse, pulsePin,
               pktReady,
               input regAck, regRdata, pktValid, pktData, pktLast, pktDest);
endinterface
`default_nettype wire

/* logic/adsc_device.sv */
// Converter sample controller: registers, calibration count, packets
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bit 24 flags drops, cleared by read
// - Width code at 17:16, left aligned, 2 reserved
// - Code 0 sends top eight bits
// - Code 1 sends 16 bits, MSB first
// - Code 3 sends 32 bits, MSB first
// - Calibration bit selects internal 0.8V reference
// - Receiver scales by 800000 over calibration
// - Pin registers read-only while enabled
// - Configure pins only while disabled
// - Six pulses after enable make no packets
// - Seventh pulse onward delivers samples
// - Calibration count restarts on each enable
// - Pin word: destination 31:8, enable 0
module adsc_device (
  // Clock and reset
  input  wire logic    sys_clk,
  input  wire logic    rstn,
  // Tile side
  adsc_if.dev          link,
  // Converter front end
  input  wire logic [11:0] extValue,
  input  wire logic [11:0] refValue,
  output logic         refSelect
);
  import adsc_pkg::*;

  typedef struct packed {
    // Per-pin words
    logic [ADSC_PINS-1:0][23:0] pinDest;
    logic [ADSC_PINS-1:0]       pinEn;
    // General control
    logic                       en;
    logic                       cal;
    logic                       drop;
    adsc_width_type             width;
    logic [2:0]                 calCnt;
    // Register answer
    logic                       regAck;
    logic [31:0]                regRdata;
    // Packet slot, shared by all pins
    logic                       pktValid;
    logic                       pktLast;
    logic [31:0]                shift;
    logic [2:0]                 left;
    logic [23:0]                dest;
  } adsc_dev_type;

  adsc_dev_type s_q;
  adsc_dev_type s_d;

  // Pin words sit one to an aligned word below the general word
  function automatic logic isPin(input logic [7:0] a);
    isPin = (a >= ADSC_PIN_BASE) && (a <= ADSC_PIN_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] pinIdx(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADSC_PIN_BASE;
    pinIdx = off[4:2];
  endfunction

  logic        dropEv;
  logic        readClr;
  logic [11:0] value;
  logic [2:0]  idx;
  logic        busy;

  // One slot only: cheaper than a queue per pin, at the cost that a
  // pulse on any enabled pin while a packet is pending counts as a lost sample
  always_comb begin
    s_d = s_q;
    s_d.regAck = 1'b0;
    dropEv = 1'b0;
    readClr = 1'b0;
    idx = pinIdx(link.regAddr);
    value = s_q.cal ? refValue : extValue;

    if (link.regReq) begin
      s_d.regAck = 1'b1;
      s_d.regRdata = 32'h00000000;
      if (link.regWrite) begin
        if (link.regAddr == ADSC_GEN_OFS) begin
          s_d.en = link.regWdata[ADSC_EN_BIT];
          s_d.cal = link.regWdata[ADSC_CAL_BIT];
          // reserved code ignored
          // Keeping the old width keeps packets well formed
          if (link.regWdata[ADSC_WIDTH_LO+:2] != ADSC_WRSV) begin
            s_d.width = adsc_width_type'(link.regWdata[ADSC_WIDTH_LO+:2]);
          end
          if (link.regWdata[ADSC_EN_BIT] && !s_q.en) begin
            s_d.calCnt = 3'h0;
          end
        end else if (isPin(link.regAddr) && !s_q.en) begin
          s_d.pinDest[idx] = link.regWdata[31:ADSC_DEST_LO];
          s_d.pinEn[idx] = link.regWdata[ADSC_PEN_BIT];
        end
      end else begin
        if (link.regAddr == ADSC_GEN_OFS) begin
          s_d.regRdata[ADSC_DROP_BIT] = s_q.drop;
          s_d.regRdata[ADSC_WIDTH_LO+:2] = s_q.width;
          s_d.regRdata[ADSC_CAL_BIT] = s_q.cal;
          s_d.regRdata[ADSC_EN_BIT] = s_q.en;
          readClr = 1'b1;
        end else if (isPin(link.regAddr)) begin
          s_d.regRdata[31:ADSC_DEST_LO] = s_q.pinDest[idx];
          s_d.regRdata[ADSC_PEN_BIT] = s_q.pinEn[idx];
        end
      end
    end

    if (s_q.pktValid && link.pktReady) begin
      if (s_q.pktLast) begin
        s_d.pktValid = 1'b0;
      end else begin
        s_d.shift = {s_q.shift[23:0], 8'h00};
        s_d.left = s_q.left - 3'h1;
        s_d.pktLast = (s_q.left == 3'h2);
      end
    end
    // The slot frees in the cycle its last byte is taken, so a pulse
    // landing on that edge is not counted as a drop
    busy = s_q.pktValid && !(link.pktReady && s_q.pktLast);

    if (link.pulse && s_q.en) begin
      if (s_q.calCnt != ADSC_CAL_PULSES) begin
        s_d.calCnt = s_q.calCnt + 3'h1;
      end else if (link.pulsePin < 3'(ADSC_PINS) && s_q.pinEn[link.pulsePin]) begin
        if (busy) begin
          dropEv = 1'b1;
        end else begin
          s_d.pktValid = 1'b1;
          s_d.dest = s_q.pinDest[link.pulsePin];
          unique case (s_q.width)
            ADSC_W8: begin
              s_d.shift = {value[11:4], 24'h000000};
              s_d.left = 3'h1;
              s_d.pktLast = 1'b1;
            end
            ADSC_W16: begin
              s_d.shift = {value, 20'h00000};
              s_d.left = 3'h2;
              s_d.pktLast = 1'b0;
            end
            default: begin
              s_d.shift = {value, 20'h00000};
              s_d.left = 3'h4;
              s_d.pktLast = 1'b0;
            end
          endcase
        end
      end
    end

    // set wins over the read clear
    s_d.drop = (s_q.drop && !readClr) || dropEv;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Drop flag starts set; the first read of the general word clears it
      s_q.pinDest <= {ADSC_PINS{ADSC_DEST_RST}};
      s_q.pinEn <= {ADSC_PINS{ADSC_PEN_RST}};
      s_q.en <= ADSC_EN_RST;
      s_q.cal <= ADSC_CAL_RST;
      s_q.drop <= ADSC_DROP_RST;
      s_q.width <= adsc_width_type'(ADSC_WIDTH_RST);
      s_q.calCnt <= 3'h0;
      s_q.regAck <= 1'b0;
      s_q.regRdata <= 32'h00000000;
      s_q.pktValid <= 1'b0;
      s_q.pktLast <= 1'b0;
      s_q.shift <= 32'h00000000;
      s_q.left <= 3'h0;
      s_q.dest <= 24'h000000;
    end else begin
      s_q <= s_d;
    end
  end


  // Every link output comes straight from the state register
  assign link.regAck = s_q.regAck;
  assign link.regRdata = s_q.regRdata;
  assign link.pktValid = s_q.pktValid;
  assign link.pktData = s_q.shift[31:24];
  assign link.pktLast = s_q.pktLast;
  assign link.pktDest = s_q.dest;
  assign refSelect = s_q.cal;
endmodule
`default_nettype wire

/* logic/adsc_driver.sv */
// Tile-side driver: AXI4-Lite commands, calibration pulses, sample intake
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adsc_driver (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Interrupt
  output logic             irq,
  // Controller side
  adsc_if.ctl              link
);
  import adsc_pkg::*;

  typedef struct packed {
    adsc_cstate_type cs;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] rdata, wreg, rdReg, sample, uv;
    logic [3:0]  status, mask;
    logic        regReq, regWrite, pulse, enSh, calSh, discard, startCal;
    logic        pktReady;
    logic [7:0]  regAddr;
    logic [2:0]  pulsePin, calCnt, rxCnt;
    logic [23:0] rxWord;
    logic [11:0] calVal, rem;
    logic [19:0] scale, quot;
    logic [4:0]  divCnt;
  } adsc_drv_type;

  adsc_drv_type s_q;
  adsc_drv_type s_d;
  logic [3:0]  setB;
  logic [3:0]  clrB;
  logic [31:0] full;
  logic [12:0] trial;
  adsc_op_type op;

  always_comb begin
    s_d = s_q;
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    s_d.arready = 1'b0;
    s_d.regReq = 1'b0;
    s_d.pulse = 1'b0;
    setB = 4'h0;
    clrB = 4'h0;
    op = adsc_op_type'(wdata[9:8]);
    full = 32'h00000000;
    trial = {s_q.rem, s_q.quot[19]};

    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    if (awvalid && wvalid && !s_q.awready && !s_q.bvalid) begin
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.bvalid = 1'b1;
      unique case (awaddr)
        ADSC_C_WDATA:  s_d.wreg = wdata;
        ADSC_C_STATUS: clrB = wdata[3:0];
        ADSC_C_MASK:   s_d.mask = wdata[3:0];
        ADSC_C_CMD: begin
          if (s_q.cs != ADSC_CS_IDLE) begin
            setB[ADSC_S_REFUSED] = 1'b1;
          end else if (op == ADSC_OP_PULSE) begin
            s_d.pulse = 1'b1;
            s_d.pulsePin = wdata[14:12];
          end else if (op == ADSC_OP_READ) begin
            s_d.regReq = 1'b1;
            s_d.regWrite = 1'b0;
            s_d.regAddr = wdata[7:0];
            s_d.cs = ADSC_CS_WAIT;
          end else if (op == ADSC_OP_WRITE && s_q.enSh &&
                       wdata[7:0] != ADSC_C_CMD && wdata[7:0] < ADSC_GEN_OFS) begin
            setB[ADSC_S_REFUSED] = 1'b1;
          end else if (op == ADSC_OP_WRITE) begin
            s_d.regReq = 1'b1;
            s_d.regWrite = 1'b1;
            s_d.regAddr = wdata[7:0];
            s_d.cs = ADSC_CS_WAIT;
            if (wdata[7:0] == ADSC_GEN_OFS) begin
              // first sample after a switch dropped
              if (s_q.wreg[ADSC_CAL_BIT] != s_q.calSh) s_d.discard = 1'b1;
              s_d.startCal = s_q.wreg[ADSC_EN_BIT] && !s_q.enSh;
              s_d.enSh = s_q.wreg[ADSC_EN_BIT];
              s_d.calSh = s_q.wreg[ADSC_CAL_BIT];
            end
          end
        end
        default: ;
      endcase
    end

    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
    if (arvalid && !s_q.arready && !s_q.rvalid) begin
      s_d.arready = 1'b1;
      s_d.rvalid = 1'b1;
      unique case (araddr)
        ADSC_C_WDATA:  s_d.rdata = s_q.wreg;
        ADSC_C_RDATA:  s_d.rdata = s_q.rdReg;
        ADSC_C_STATUS: s_d.rdata = {28'h0000000, s_q.status};
        ADSC_C_MASK:   s_d.rdata = {28'h0000000, s_q.mask};
        ADSC_C_SAMPLE: s_d.rdata = s_q.sample;
        ADSC_C_SCALE:  s_d.rdata = {12'h000, s_q.scale};
        ADSC_C_UV:     s_d.rdata = s_q.uv;
        default:       s_d.rdata = 32'h00000000;
      endcase
    end

    unique case (s_q.cs)
      ADSC_CS_IDLE: ;
      ADSC_CS_WAIT: begin
        if (link.regAck) begin
          s_d.rdReg = link.regRdata;
          setB[ADSC_S_DONE] = 1'b1;
          s_d.cs = s_q.startCal ? ADSC_CS_CAL : ADSC_CS_IDLE;
          s_d.calCnt = ADSC_CAL_PULSES;
          s_d.startCal = 1'b0;
        end
      end
      // six calibration pulses, every other cycle
      ADSC_CS_CAL: begin
        if (!s_q.pulse) begin
          s_d.pulse = 1'b1;
          s_d.pulsePin = 3'h0;
          s_d.calCnt = s_q.calCnt - 3'h1;
          if (s_q.calCnt == 3'h1) s_d.cs = ADSC_CS_IDLE;
        end
      end
      default: s_d.cs = ADSC_CS_IDLE;
    endcase

    // serial division of 800000 by the calibration value
    if (s_q.divCnt != 5'h00) begin
      s_d.divCnt = s_q.divCnt - 5'h01;
      if (trial >= {1'b0, s_q.calVal}) begin
        s_d.rem = 12'(trial - {1'b0, s_q.calVal});
        s_d.quot = {s_q.quot[18:0], 1'b1};
      end else begin
        s_d.rem = trial[11:0];
        s_d.quot = {s_q.quot[18:0], 1'b0};
      end
      if (s_q.divCnt == 5'h01) begin
        s_d.scale = s_d.quot;
        setB[ADSC_S_SCALE] = 1'b1;
      end
    end

    // Intake stalls while the scale is being worked out
    s_d.pktReady = (s_d.divCnt == 5'h00);
    if (link.pktValid && s_q.pktReady) begin
      s_d.rxWord = {s_q.rxWord[15:0], link.pktData};
      s_d.rxCnt = s_q.rxCnt + 3'h1;
      if (link.pktLast) begin
        s_d.rxCnt = 3'h0;
        unique case (s_q.rxCnt)
          3'h0:    full = {link.pktData, 24'h000000};
          3'h1:    full = {s_q.rxWord[7:0], link.pktData, 16'h0000};
          default: full = {s_q.rxWord, link.pktData};
        endcase
        if (s_q.discard) begin
          s_d.discard = 1'b0;
        end else if (s_q.calSh) begin
          s_d.calVal = full[31:20];
          s_d.rem = 12'h000;
          s_d.quot = ADSC_UV_NUM;
          s_d.divCnt = ADSC_DIV_STEPS;
          s_d.pktReady = 1'b0;
        end else begin
          s_d.sample = full;
          s_d.uv = 32'(full[31:20]) * 32'(s_q.scale);
          setB[ADSC_S_SAMPLE] = 1'b1;
        end
      end
    end

    // Set wins over the write-one clear
    s_d.status = (s_q.status & ~clrB) | setB;
    s_d.irq = |(s_q.status & s_q.mask);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.cs <= ADSC_CS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = 2'h0;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = 2'h0;
  assign irq = s_q.irq;
  assign link.regReq = s_q.regReq;
  assign link.regWrite = s_q.regWrite;
  assign link.regAddr = s_q.regAddr;
  assign link.regWdata = s_q.wreg;
  assign link.pulse = s_q.pulse;
  assign link.pulsePin = s_q.pulsePin;
  assign link.pktReady = s_q.pktReady;
endmodule
`default_nettype wire

/* testbench/adsc_link_chk.sv */
// Checker for the register, pulse and packet signals of the link
`timescale 1ns/1ps
`default_nettype none
module adsc_link_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register access
  input wire logic        regReq,
  input wire logic        regWrite,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regAck,
  input wire logic [31:0] regRdata,
  // Pulses and packets
  input wire logic        pulse,
  input wire logic [2:0]  pulsePin,
  input wire logic        pktValid,
  input wire logic [7:0]  pktData,
  input wire logic        pktLast,
  input wire logic [23:0] pktDest,
  input wire logic        pktReady
);
  import adsc_pkg::*;
  logic        en_q;
  logic        rdPin_q;
  logic [1:0]  wid_q;
  logic [2:0]  cnt_q;
  logic [2:0]  rdIdx_q;
  logic [31:0] pin_q [7];
  wire logic [2:0] idx = regAddr[4:2] - 3'h1;
  wire logic       isPin = regAddr >= ADSC_PIN_BASE && regAddr <= ADSC_PIN_LAST
                           && regAddr[1:0] == 2'h0;
  wire logic       genWr = regReq && regWrite && regAddr == ADSC_GEN_OFS;

  // Shadow of what the controller should hold, built from taken writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
      wid_q <= 2'h1;
      cnt_q <= 3'h0;
      rdPin_q <= 1'b0;
      rdIdx_q <= 3'h0;
      for (int i = 0; i < 7; i++) pin_q[i] <= 32'h0;
    end else begin
      if (regReq) rdPin_q <= isPin && !regWrite;
      if (regReq) rdIdx_q <= idx;
      if (genWr) en_q <= regWdata[0];
      if (genWr && regWdata[17:16] != 2'h2) wid_q <= regWdata[17:16];
      if (genWr && regWdata[0] && !en_q) cnt_q <= 3'h0;
      else if (pulse && en_q && cnt_q < ADSC_CAL_PULSES) cnt_q <= cnt_q + 3'h1;
      if (regReq && regWrite && isPin && !en_q)
        pin_q[idx] <= {regWdata[31:8], 7'h0, regWdata[0]};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_ACK_NEXT: assert property (regReq |=> regAck)
    else $error("request not answered next cycle");
  AST_PIN_READ: assert property (regAck && rdPin_q |-> regRdata == pin_q[rdIdx_q])
    else $error("pin word read back wrong");
  AST_CAL_QUIET: assert property (pulse && en_q && cnt_q < ADSC_CAL_PULSES
    && !pktValid |=> !pktValid) else $error("packet during calibration");
  AST_SEVENTH: assert property (pulse && en_q && cnt_q == ADSC_CAL_PULSES
    && pin_q[pulsePin][0] && !pktValid |=> pktValid) else $error("sample missing");
  AST_HOLD: assert property (pktValid && !pktReady |=> pktValid && $stable(pktData)
    && $stable(pktLast) && $stable(pktDest)) else $error("byte not held");
  AST_W8: assert property ($rose(pktValid) && wid_q == 2'h0 |-> pktLast)
    else $error("8-bit sample not one byte");
  AST_W16: assert property (pktValid && pktReady && !pktLast && wid_q == 2'h1
    |=> pktLast && pktData[3:0] == 4'h0) else $error("16-bit tail wrong");
  AST_W32: assert property (pktValid && pktLast && wid_q == 2'h3
    |-> pktData == 8'h00) else $error("32-bit pad not zero");
  AST_W16_HEAD: assert property ($rose(pktValid) && wid_q == 2'h1 |-> !pktLast)
    else $error("16-bit sample too short");
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Bench: driver and controller joined by the link, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adsc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, irq, refSelect;
  logic [1:0]  bresp, rresp;
  logic [11:0] extValue = 12'ha5c, refValue = 12'h7d0;
  logic [23:0] lastDest = 24'h0;
  logic [1:0]  codes [3] = '{2'h0, 2'h1, 2'h3};
  int          errCount = 0, testsRun = 0, cycles = 0, pkts = 0;

  always #12.5 sys_clk = ~sys_clk;

  adsc_if link ();
  adsc_device adsc_device_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link.dev),
    .extValue(extValue), .refValue(refValue), .refSelect(refSelect));
  adsc_driver adsc_driver_inst (.sys_clk(sys_clk), .rstn(rstn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq), .link(link.ctl));
  adsc_link_chk adsc_link_chk_inst (.sys_clk(sys_clk), .rstn(rstn),
    .regReq(link.regReq), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regAck(link.regAck), .regRdata(link.regRdata),
    .pulse(link.pulse), .pulsePin(link.pulsePin), .pktValid(link.pktValid),
    .pktData(link.pktData), .pktLast(link.pktLast), .pktDest(link.pktDest),
    .pktReady(link.pktReady));

  task automatic finalReport();
    $display("Checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Packet counter and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (link.pktValid && link.pktReady && link.pktLast) pkts <= pkts + 1;
    if (link.pktValid) lastDest <= link.pktDest;
    if (cycles == 20000) begin
      errCount++;
      finalReport();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b1;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) b = 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask

  // Poll one status bit, then clear it
  task automatic waitStat(input int b);
    logic [31:0] s;
    s = 32'h0;
    while (s[b] !== 1'b1) axiRd(ADSC_C_STATUS, s);
    axiWr(ADSC_C_STATUS, 32'h1 << b);
  endtask

  task automatic devCmd(input adsc_op_type op, input logic [7:0] a,
                        input logic [31:0] d, input int stat);
    axiWr(ADSC_C_WDATA, d);
    axiWr(ADSC_C_CMD, {22'h0, op, a});
    waitStat(stat);
  endtask

  task automatic devRd(input logic [7:0] a);
    devCmd(ADSC_OP_READ, a, 32'h0, ADSC_S_DONE);
    axiRd(ADSC_C_RDATA, rd);
  endtask

  task automatic pulse0();
    axiWr(ADSC_C_CMD, {22'h0, ADSC_OP_PULSE, 8'h00});
  endtask

  task automatic waitPkt(input int n);
    while (pkts < n) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] alignVal(input logic [1:0] w,
                                           input logic [11:0] v);
    case (w)
      2'h0: return {v[11:4], 24'h0};
      2'h1: return {v, 4'h0, 16'h0};
      default: return {v, 20'h0};
    endcase
  endfunction

  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    devRd(ADSC_GEN_OFS);
    check("general init", rd, 32'h0101_0000);
    devRd(ADSC_GEN_OFS);
    check("drop cleared", rd, 32'h0001_0000);
    axiRd(8'h3c, rd);
    check("unmapped", rd, 32'h0);
    devCmd(ADSC_OP_WRITE, ADSC_PIN_BASE, 32'habcdef01, ADSC_S_DONE);
    devRd(ADSC_PIN_BASE);
    check("pin 0", rd, 32'habcdef01);
    devCmd(ADSC_OP_WRITE, ADSC_PIN_LAST, 32'h123456fe, ADSC_S_DONE);
    devRd(ADSC_PIN_LAST);
    check("pin 6", rd, 32'h12345600);
    // Each width: disable, enable, six quiet pulses, then one sample
    foreach (codes[i]) begin
      devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, {14'h0, codes[i], 16'h0}, ADSC_S_DONE);
      devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, {14'h0, codes[i], 16'h1}, ADSC_S_DONE);
      repeat (14) @(posedge sys_clk);
      check("calibration packets", 32'(pkts), 32'(i));
      pulse0();
      waitStat(ADSC_S_SAMPLE);
      axiRd(ADSC_C_SAMPLE, rd);
      check("sample", rd, alignVal(codes[i], extValue));
      check("destination", {8'h0, lastDest}, 32'h00abcdef);
    end
    // Reserved width code leaves the width alone
    devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, 32'h0002_0000, ADSC_S_DONE);
    devRd(ADSC_GEN_OFS);
    check("reserved width", rd, 32'h0003_0000);
    devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, 32'h0001_0001, ADSC_S_DONE);
    repeat (14) @(posedge sys_clk);
    devCmd(ADSC_OP_WRITE, ADSC_PIN_BASE, 32'h0, ADSC_S_REFUSED);
    devRd(ADSC_PIN_BASE);
    check("pin locked", rd, 32'habcdef01);
    // Calibration: the slow division stalls intake; the next pulse waits in the slot, the one after drops
    devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, 32'h0001_0003, ADSC_S_DONE);
    check("reference on", {31'h0, refSelect}, 32'h1);
    pulse0();
    waitPkt(4);
    pulse0();
    pulse0();
    pulse0();
    waitStat(ADSC_S_SCALE);
    axiRd(ADSC_C_SCALE, rd);
    check("scale", rd, 32'd800000 / 32'(refValue));
    devRd(ADSC_GEN_OFS);
    check("drop set", rd, 32'h0101_0003);
    devRd(ADSC_GEN_OFS);
    check("drop read clear", rd, 32'h0001_0003);
    devCmd(ADSC_OP_WRITE, ADSC_GEN_OFS, 32'h0001_0001, ADSC_S_DONE);
    check("reference off", {31'h0, refSelect}, 32'h0);
    axiWr(ADSC_C_STATUS, 32'hf);
    axiWr(ADSC_C_MASK, 32'h0);
    pulse0();
    waitPkt(pkts + 1);
    pulse0();
    do axiRd(ADSC_C_STATUS, rd); while (rd[ADSC_S_SAMPLE] !== 1'b1);
    check("irq masked", {31'h0, irq}, 32'h0);
    axiRd(ADSC_C_UV, rd);
    check("microvolts", rd, 32'(extValue) * (32'd800000 / 32'(refValue)));
    axiWr(ADSC_C_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    axiWr(ADSC_C_STATUS, 32'h2);
    repeat (2) @(posedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    check("write response", {30'h0, bresp}, 32'h0);
    check("read response", {30'h0, rresp}, 32'h0);
    finalReport();
  end
endmodule
`default_nettype wire
